// ---- rtl/ccu_pkg.sv ----
// Package of constants shared by the card command unit.
package ccu_pkg;
  localparam logic [7:0] OP_UNLOCK     = 8'h00F2;
  localparam logic [7:0] OP_ERASE_UNIT = 8'h00F4;
  localparam logic [3:0] OP_SEEK_HI    = 4'h7;
  localparam logic [7:0] OP_SETFEAT    = 8'h00EF;
  localparam logic [7:0] OP_SETMULT    = 8'h00C6;
  localparam logic [7:0] OP_SLEEP_A    = 8'h0099;
  localparam logic [7:0] OP_SLEEP_B    = 8'h00E6;

  localparam logic [7:0] SF_8BIT_ON    = 8'h0001;
  localparam logic [7:0] SF_WC_ON      = 8'h0002;
  localparam logic [7:0] SF_XFER_MODE  = 8'h0003;
  localparam logic [7:0] SF_APM_ON     = 8'h0005;
  localparam logic [7:0] SF_XPWR_ON    = 8'h0009;
  localparam logic [7:0] SF_PL1_ON     = 8'h000A;
  localparam logic [7:0] SF_ECC_VEND   = 8'h0044;
  localparam logic [7:0] SF_RLA_OFF    = 8'h0055;
  localparam logic [7:0] SF_KEEP_ON    = 8'h0066;
  localparam logic [7:0] SF_NOP_A      = 8'h0069;
  localparam logic [7:0] SF_8BIT_OFF   = 8'h0081;
  localparam logic [7:0] SF_WC_OFF     = 8'h0082;
  localparam logic [7:0] SF_APM_OFF    = 8'h0085;
  localparam logic [7:0] SF_XPWR_OFF   = 8'h0089;
  localparam logic [7:0] SF_PL1_OFF    = 8'h008A;
  localparam logic [7:0] SF_NOP_B      = 8'h0096;
  localparam logic [7:0] SF_COMPAT     = 8'h0097;
  localparam logic [7:0] SF_CURRENT    = 8'h009A;
  localparam logic [7:0] SF_RLA_ON     = 8'h00AA;
  localparam logic [7:0] SF_ECC_FOUR   = 8'h00BB;
  localparam logic [7:0] SF_KEEP_OFF   = 8'h00CC;

  localparam logic [4:0] XT_PIO        = 5'h01;
  localparam logic [4:0] XT_MDMA       = 5'h04;
  localparam int         XT_TYPE_LSB   = 3;
  localparam logic [2:0] PIO_DEFAULT   = 3'h0;
  localparam logic [2:0] MDMA_DEFAULT  = 3'h0;

  localparam logic [2:0] UNLOCK_TRIES  = 3'h5;
  localparam logic [7:0] ECC_FOUR_LEN  = 8'h04;
  localparam int         CW_ID_BIT     = 0;

  localparam int CLK_HZ        = 40_000_000;
  localparam int IDLE_MS       = 5;
  localparam int IDLE_CYCLES   = CLK_HZ / 1000 * IDLE_MS;

  localparam logic [7:0] ERR_ABRT      = 8'h04;
  localparam logic [7:0] ERR_IDNF      = 8'h10;
endpackage : ccu_pkg

// ---- rtl/ccu_pw_compare.sv ----
// Streaming password comparator for one received data sector.
`timescale 1ns/10ps
`default_nettype none
module ccu_pw_compare
  import ccu_pkg::*;
#(
  parameter int PW_WORDS = 16
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                start,
  input  wire logic                wordValid,
  input  wire logic [15:0]         wordData,
  input  wire logic [16*PW_WORDS-1:0] refPw,
  input  wire logic [16*PW_WORDS-1:0] refPwAlt,
  output logic                     useAlt,
  output logic                     match,
  output logic                     done
);
  localparam int CW = $clog2(256 + 1);
  logic [CW-1:0] idx_ff;
  logic          busy_ff;
  logic [16*PW_WORDS-1:0] sel;
  initial if (PW_WORDS < 1 || PW_WORDS > 255) $error("bad PW_WORDS");

  assign sel = useAlt ? refPwAlt : refPw;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      idx_ff  <= '0;
      busy_ff <= 1'b0;
      useAlt  <= 1'b0;
      match   <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        idx_ff  <= '0;
        busy_ff <= 1'b1;
        match   <= 1'b1;
      end else if (busy_ff && wordValid) begin
        if (idx_ff == '0) begin
          useAlt <= wordData[CW_ID_BIT];
        end else if (idx_ff <= CW'(PW_WORDS)) begin
          if (wordData != sel[16*(int'(idx_ff)-1) +: 16]) begin
            match <= 1'b0;
          end
        end
        if (idx_ff == CW'(255)) begin
          busy_ff <= 1'b0;
          done    <= 1'b1;
        end
        idx_ff <= idx_ff + CW'(1);
      end
    end
  end
endmodule // ccu_pw_compare
`default_nettype wire

// ---- rtl/ccu_cmd_unit.sv ----
// Command execution unit for unlock, seek, features, multiple and sleep.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Unlock takes one sector; id bit picks password.
// - Maximum security rejects master unlock without compare.
// - Mismatch aborts and decrements the attempt counter.
// - Attempt counter starts at five.
// - Counter zero aborts unlock, erase until power-on or hardware reset.
// - Unlock while unlocked leaves counter alone.
// - Seek only range-checks address, errors if out.
// - Set features decodes feature, value from count.
// - Eight-bit mode uses low lanes, no 16-bit flag.
// - Write cache on/off; off flushes before completion.
// - Transfer mode: type upper five, mode low three.
// - Exactly one PIO and one DMA mode.
// - Power management, extended power, level one toggles.
// - Read look-ahead off 55h, on AAh.
// - 66h keeps settings on soft reset, CCh restores.
// - BBh four check bytes, 44h product count.
// - Set multiple: busy, valid count enables multiple.
// - Bad count aborts and disables; zero disables.
// - Resets default multiple to disabled; soft reset after 66h keeps it.
// - Sleep command: busy, sleep, unbusy, interrupt.
// - Idle timer enters sleep after five milliseconds.
module ccu_cmd_unit
  import ccu_pkg::*;
#(
  parameter int          IDLE_TICKS  = IDLE_CYCLES,
  parameter int          PW_WORDS    = 16,
  parameter logic [7:0]  MAX_BLOCK   = 8'h01,
  parameter logic [7:0]  VEND_ECC    = 8'h04,
  parameter logic [27:0] LBA_LIMIT   = 28'h000_FFFF,
  parameter logic [15:0] CYL_LIMIT   = 16'h0100,
  parameter logic [3:0]  HEAD_LIMIT  = 4'h4,
  parameter logic [7:0]  SPT_LIMIT   = 8'h20,
  parameter bit          DMA_CAPABLE = 1'b1,
  parameter logic [2:0]  PIO_MAX     = 3'h4,
  parameter logic [2:0]  MDMA_MAX    = 3'h2
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   hwReset,
  input  wire logic                   softReset,
  input  wire logic                   cmdValid,
  input  wire logic [7:0]             cmdCode,
  input  wire logic [7:0]             featureReg,
  input  wire logic [7:0]             sectorCount,
  input  wire logic [7:0]             sectorNumber,
  input  wire logic [15:0]            cylinder,
  input  wire logic [3:0]             headReg,
  input  wire logic                   lbaMode,
  input  wire logic                   dataValid,
  input  wire logic [15:0]            dataWord,
  input  wire logic                   locked,
  input  wire logic                   highSecurity,
  input  wire logic [16*PW_WORDS-1:0] userPw,
  input  wire logic [16*PW_WORDS-1:0] masterPw,
  input  wire logic                   flushDone,
  input  wire logic                   dataRegAccess,
  output logic                        busy_flag,
  output logic                        errorFlag,
  output logic [7:0]                  errorCode,
  output logic                        irqPulse,
  output logic                        unlockOk,
  output logic                        flushReq,
  output logic [2:0]                  unlockTries,
  output logic                        eightBitMode,
  output logic                        sixteen_bit_io_flag,
  output logic                        writeCacheOn,
  output logic [2:0]                  pioMode,
  output logic [2:0]                  mdmaMode,
  output logic                        apmOn,
  output logic                        extPowerOn,
  output logic                        pwrLevel1On,
  output logic                        readAheadOn,
  output logic                        keepOnSoftReset,
  output logic [7:0]                  longEccBytes,
  output logic                        multipleOn,
  output logic [7:0]                  blockSize,
  output logic                        sleeping
);
  localparam int TW = $clog2(IDLE_TICKS + 1);
  initial if (IDLE_TICKS < 1 || MAX_BLOCK == 8'h00) $error("bad params");

  typedef enum {ST_IDLE, ST_PW, ST_FLUSH, ST_DONE} ccu_state_t;
  ccu_state_t state_ff;

  logic [TW-1:0] idle_ff;
  logic pwStart, pwMatch, pwDone, pwAlt;
  logic rstDefaults;
  logic abort, sfKnown;
  logic [7:0] xType;

  function automatic logic addrOk(input logic lba, input logic [3:0] hd,
                                  input logic [15:0] cyl,
                                  input logic [7:0] sec);
    if (lba) begin
      addrOk = {hd, cyl, sec} < LBA_LIMIT;
    end else begin
      addrOk = (cyl < CYL_LIMIT) && (hd < HEAD_LIMIT) && (sec != 8'h00)
               && (sec <= SPT_LIMIT);
    end
  endfunction

  // Power-on and hardware resets always restore defaults; soft reset only
  // when retention has not been requested.
  assign rstDefaults = hwReset || (softReset && !keepOnSoftReset);

  assign xType = {3'b000, sectorCount[7:XT_TYPE_LSB]};

  always_comb begin
    case (featureReg)
      SF_8BIT_ON, SF_WC_ON, SF_APM_ON, SF_XPWR_ON, SF_PL1_ON, SF_ECC_VEND,
      SF_RLA_OFF, SF_KEEP_ON, SF_NOP_A, SF_8BIT_OFF, SF_WC_OFF, SF_APM_OFF,
      SF_XPWR_OFF, SF_PL1_OFF, SF_NOP_B, SF_COMPAT, SF_CURRENT, SF_RLA_ON,
      SF_ECC_FOUR, SF_KEEP_OFF: sfKnown = 1'b1;
      SF_XFER_MODE: sfKnown =
        (xType[4:0] == XT_PIO && sectorCount[2:0] <= PIO_MAX) ||
        (DMA_CAPABLE && xType[4:0] == XT_MDMA &&
         sectorCount[2:0] <= MDMA_MAX);
      default: sfKnown = 1'b0;
    endcase
  end

  // The sector is consumed even when unlocked, so the host never stalls.
  assign pwStart = ce && cmdValid && state_ff == ST_IDLE &&
                   cmdCode == OP_UNLOCK && unlockTries != 3'h0;

  ccu_pw_compare #(.PW_WORDS(PW_WORDS)) u_cmp (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .start     (pwStart),
    .wordValid (dataValid),
    .wordData  (dataWord),
    .refPw     (userPw),
    .refPwAlt  (masterPw),
    .useAlt    (pwAlt),
    .match     (pwMatch),
    .done      (pwDone)
  );

  // Command sequencing, status and unlock bookkeeping.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      busy_flag   <= 1'b0;
      errorFlag   <= 1'b0;
      errorCode   <= 8'h00;
      irqPulse    <= 1'b0;
      unlockOk    <= 1'b0;
      flushReq    <= 1'b0;
      unlockTries <= UNLOCK_TRIES;
      sleeping    <= 1'b0;
      idle_ff     <= '0;
    end else if (ce) begin
      irqPulse <= 1'b0;
      unlockOk <= 1'b0;
      if (hwReset) begin
        unlockTries <= UNLOCK_TRIES;
      end
      case (state_ff)
        ST_IDLE: begin
          if (cmdValid) begin
            busy_flag <= 1'b1;
            errorFlag <= 1'b0;
            errorCode <= 8'h00;
            sleeping  <= 1'b0;
            idle_ff   <= '0;
            state_ff  <= ST_DONE;
            if (cmdCode == OP_UNLOCK || cmdCode == OP_ERASE_UNIT) begin
              if (unlockTries == 3'h0) begin
                errorFlag <= 1'b1;
                errorCode <= ERR_ABRT;
              end else if (cmdCode == OP_UNLOCK) begin
                state_ff <= ST_PW;
              end
            end else if (cmdCode[7:4] == OP_SEEK_HI) begin
              if (!addrOk(lbaMode, headReg, cylinder, sectorNumber)) begin
                errorFlag <= 1'b1;
                errorCode <= ERR_IDNF;
              end
            end else if (cmdCode == OP_SETFEAT) begin
              if (!sfKnown) begin
                errorFlag <= 1'b1;
                errorCode <= ERR_ABRT;
              end else if (featureReg == SF_WC_OFF && writeCacheOn) begin
                flushReq <= 1'b1;
                state_ff <= ST_FLUSH;
              end
            end else if (cmdCode == OP_SETMULT) begin
              if (sectorCount > MAX_BLOCK) begin
                errorFlag <= 1'b1;
                errorCode <= ERR_ABRT;
              end
            end else if (cmdCode == OP_SLEEP_A || cmdCode == OP_SLEEP_B) begin
              sleeping <= 1'b1;
            end
          end else if (!busy_flag && !sleeping) begin
            if (idle_ff == TW'(IDLE_TICKS - 1)) begin
              sleeping <= 1'b1;
              idle_ff  <= '0;
            end else begin
              idle_ff <= idle_ff + TW'(1);
            end
          end
        end
        ST_PW: begin
          if (pwDone) begin
            state_ff <= ST_DONE;
            if (pwAlt && !highSecurity) begin
              errorFlag <= 1'b1;
              errorCode <= ERR_ABRT;
            end else if (!locked) begin
              unlockOk <= 1'b1;
            end else if (pwMatch) begin
              unlockOk <= 1'b1;
            end else begin
              errorFlag <= 1'b1;
              errorCode <= ERR_ABRT;
              if (!hwReset) begin
                unlockTries <= unlockTries - 3'h1;
              end
            end
          end
        end
        ST_FLUSH: begin
          if (flushDone) begin
            flushReq <= 1'b0;
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          busy_flag <= 1'b0;
          irqPulse  <= 1'b1;
          state_ff  <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Feature settings; an unsupported code changes nothing.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      eightBitMode    <= 1'b0;
      writeCacheOn    <= 1'b0;
      pioMode         <= PIO_DEFAULT;
      mdmaMode        <= MDMA_DEFAULT;
      apmOn           <= 1'b0;
      extPowerOn      <= 1'b0;
      pwrLevel1On     <= 1'b0;
      readAheadOn     <= 1'b1;
      keepOnSoftReset <= 1'b0;
      longEccBytes    <= ECC_FOUR_LEN;
    end else if (ce) begin
      if (rstDefaults) begin
        eightBitMode    <= 1'b0;
        writeCacheOn    <= 1'b0;
        pioMode         <= PIO_DEFAULT;
        mdmaMode        <= MDMA_DEFAULT;
        apmOn           <= 1'b0;
        extPowerOn      <= 1'b0;
        pwrLevel1On     <= 1'b0;
        readAheadOn     <= 1'b1;
        keepOnSoftReset <= 1'b0;
        longEccBytes    <= ECC_FOUR_LEN;
      end else if (state_ff == ST_IDLE && cmdValid &&
                   cmdCode == OP_SETFEAT && sfKnown) begin
        case (featureReg)
          SF_8BIT_ON:  eightBitMode    <= 1'b1;
          SF_8BIT_OFF: eightBitMode    <= 1'b0;
          SF_WC_ON:    writeCacheOn    <= 1'b1;
          SF_WC_OFF:   writeCacheOn    <= 1'b0;
          SF_APM_ON:   apmOn           <= 1'b1;
          SF_APM_OFF:  apmOn           <= 1'b0;
          SF_XPWR_ON:  extPowerOn      <= 1'b1;
          SF_XPWR_OFF: extPowerOn      <= 1'b0;
          SF_PL1_ON:   pwrLevel1On     <= 1'b1;
          SF_PL1_OFF:  pwrLevel1On     <= 1'b0;
          SF_RLA_OFF:  readAheadOn     <= 1'b0;
          SF_RLA_ON:   readAheadOn     <= 1'b1;
          SF_KEEP_ON:  keepOnSoftReset <= 1'b1;
          SF_KEEP_OFF: keepOnSoftReset <= 1'b0;
          SF_ECC_FOUR: longEccBytes    <= ECC_FOUR_LEN;
          SF_ECC_VEND: longEccBytes    <= VEND_ECC;
          SF_XFER_MODE: begin
            // One register per class keeps exactly one mode selected.
            if (xType[4:0] == XT_PIO) begin
              pioMode <= sectorCount[2:0];
            end else begin
              mdmaMode <= sectorCount[2:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Multiple-sector block size.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      multipleOn <= 1'b0;
      blockSize  <= 8'h00;
    end else if (ce) begin
      if (rstDefaults) begin
        multipleOn <= 1'b0;
        blockSize  <= 8'h00;
      end else if (state_ff == ST_IDLE && cmdValid &&
                   cmdCode == OP_SETMULT) begin
        if (sectorCount == 8'h00 || sectorCount > MAX_BLOCK) begin
          multipleOn <= 1'b0;
        end else begin
          multipleOn <= 1'b1;
          blockSize  <= sectorCount;
        end
      end
    end
  end

  // The 16-bit flag is withheld from data accesses in byte mode only.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sixteen_bit_io_flag <= 1'b0;
    end else if (ce) begin
      sixteen_bit_io_flag <= dataRegAccess && !eightBitMode;
    end
  end
endmodule // ccu_cmd_unit
`default_nettype wire

// ---- testbench/ccu_cmd_asserts.sv ----
// Port-level checks for the card command unit.
`timescale 1ns/10ps
`default_nettype none
module ccu_cmd_asserts
  import ccu_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       hwReset,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] featureReg,
  input wire logic       dataRegAccess,
  input wire logic       busy_flag,
  input wire logic       errorFlag,
  input wire logic [7:0] errorCode,
  input wire logic       irqPulse,
  input wire logic [2:0] unlockTries,
  input wire logic       eightBitMode,
  input wire logic       sixteen_bit_io_flag,
  input wire logic       multipleOn,
  input wire logic       sleeping
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire take = cmdValid && !busy_flag && ce;
  property p_busy;
    take |=> busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_sleep;
    take && (cmdCode == OP_SLEEP_A || cmdCode == OP_SLEEP_B)
      |-> ##2 sleeping && irqPulse && !busy_flag;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_io_on;
    dataRegAccess && !eightBitMode |=> sixteen_bit_io_flag;
  endproperty
  a_io_on: assert property (p_io_on) else $error("io16 low");
  property p_io_off;
    eightBitMode |=> !sixteen_bit_io_flag;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io16 high");
  property p_tries_zero;
    unlockTries == 3'h0 && !hwReset |=> unlockTries == 3'h0;
  endproperty
  a_tries_zero: assert property (p_tries_zero) else $error("tries");
  property p_tries_step;
    $changed(unlockTries) && !$past(hwReset)
      |-> unlockTries == $past(unlockTries) - 3'h1;
  endproperty
  a_tries_step: assert property (p_tries_step) else $error("step");
  property p_feat_bad;
    take && cmdCode == OP_SETFEAT && featureReg == 8'h00
      |-> ##2 errorFlag && errorCode == ERR_ABRT && $stable(eightBitMode);
  endproperty
  a_feat_bad: assert property (p_feat_bad) else $error("feature");
  property p_hw;
    hwReset |=> unlockTries == UNLOCK_TRIES && !multipleOn;
  endproperty
  a_hw: assert property (p_hw) else $error("hw reset");
endmodule // ccu_cmd_asserts
`default_nettype wire

// ---- testbench/ccu_host_model.sv ----
// Host controller model that writes the task file and sends sectors.
`timescale 1ns/10ps
`default_nettype none
module ccu_host_model (
  input  wire logic  clk,
  input  wire logic  busy_flag,
  input  wire logic  flushReq,
  output logic       cmdValid,
  output logic [7:0] cmdCode,
  output logic [7:0] featureReg,
  output logic [7:0] sectorCount,
  output logic [7:0] sectorNumber,
  output logic [15:0] cylinder,
  output logic [3:0] headReg,
  output logic       lbaMode,
  output logic       dataValid,
  output logic [15:0] dataWord,
  output logic       flushDone
);
  int flushN = 0;
  int fc = 0;
  initial begin
    {cmdValid, cmdCode, featureReg, sectorCount, sectorNumber} = '0;
    {cylinder, headReg, lbaMode, dataValid, dataWord, flushDone} = '0;
  end
  // It issues no DMA, so eight-bit mode never meets a DMA transfer.
  task automatic cmd(input logic [7:0] c, f, n, input logic [28:0] a);
    @(negedge clk);
    {cmdCode, featureReg, sectorCount} = {c, f, n};
    {lbaMode, headReg, cylinder, sectorNumber} = a;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask
  // Words flow only while busy; a gap now and then mimics a slow host.
  task automatic sector(input logic [15:0] w0, input logic [31:0] pw);
    for (int i = 0; i < 256 && busy_flag === 1'b1; i++) begin
      if (i[5:0] == 6'h20) begin
        dataValid = 1'b0;
        dataWord = ~dataWord;
        @(negedge clk);
      end
      dataWord = (i == 0) ? w0 : (i == 1) ? pw[15:0] :
                 (i == 2) ? pw[31:16] : i[15:0];
      dataValid = 1'b1;
      @(negedge clk);
    end
    dataValid = 1'b0;
    dataWord = ~dataWord;
  endtask
  // The back end ends a flush a few cycles after it is asked.
  always @(negedge clk) begin
    fc = flushReq ? fc + 1 : 0;
    flushDone = (fc == 6);
    if (fc == 6) flushN++;
  end
endmodule // ccu_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the card command unit.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ccu_pkg::*;
;
  logic clk = 0, rstn = 0, ce = 1, hwReset = 0, softReset = 0;
  logic locked = 1, highSecurity = 0, dataRegAccess = 0;
  logic [31:0] userPw = 32'h1234_5678, masterPw = 32'h9ABC_DEF0;
  logic cmdValid, lbaMode, dataValid, flushDone, flushReq, busy_flag;
  logic errorFlag, irqPulse, unlockOk, eightBitMode, sixteen_bit_io_flag;
  logic writeCacheOn, apmOn, extPowerOn, pwrLevel1On, readAheadOn;
  logic keepOnSoftReset, multipleOn, sleeping, okS, irqS;
  logic [7:0] cmdCode, featureReg, sectorCount, sectorNumber, errorCode;
  logic [7:0] longEccBytes, blockSize;
  logic [15:0] cylinder, dataWord;
  logic [3:0] headReg;
  logic [2:0] unlockTries, pioMode, mdmaMode;
  int err_total = 0, compares = 0, cyc = 0;
  wire [6:0] st = {eightBitMode, writeCacheOn, apmOn, extPowerOn,
                   pwrLevel1On, readAheadOn, keepOnSoftReset};
  logic [7:0] ft [14] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h0A, 8'h55, 8'h66,
                          8'h81, 8'h82, 8'h85, 8'h89, 8'h8A, 8'hAA, 8'hCC};
  logic [6:0] fs [14] = '{7'h42, 7'h62, 7'h72, 7'h7A, 7'h7E, 7'h7C, 7'h7D,
                          7'h3D, 7'h1D, 7'h0D, 7'h05, 7'h01, 7'h03, 7'h02};
  ccu_cmd_unit #(.IDLE_TICKS(20), .PW_WORDS(2), .VEND_ECC(8'h08)) dut (.*);
  ccu_host_model host (.*);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang ends here rather than running forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic fin(input logic [7:0] e);
    okS = 1'b0;
    irqS = 1'b0;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk);
      okS |= unlockOk;
      irqS |= irqPulse;
      if (busy_flag === 1'b0) break;
    end
    chk("irq", irqS, 1'b1);
    chk("err", errorFlag, e != 8'h00);
    if (e != 8'h00) chk("code", errorCode, e);
  endtask
  task automatic run(input logic [7:0] c, f = 8'h00, n = 8'h00,
                     e = 8'h00, input logic [28:0] a = '0);
    host.cmd(c, f, n, a);
    fin(e);
  endtask
  task automatic unl(input logic [7:0] c, input logic [15:0] w0,
                     input logic [31:0] pw, input logic [7:0] e);
    host.cmd(c, 8'h00, 8'h00, '0);
    fork
      host.sector(w0, pw);
      fin(e);
    join
  endtask
  task automatic pulse(input bit hw);
    @(negedge clk);
    hwReset = hw;
    softReset = !hw;
    @(negedge clk);
    hwReset = 1'b0;
    softReset = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk("tries", unlockTries, UNLOCK_TRIES);
    chk("feat", st, 7'h02);
    chk("ecc", longEccBytes, ECC_FOUR_LEN);
    chk("mult", multipleOn, 1'b0);
    dataRegAccess = 1'b1;
    for (int i = 0; i < 14; i++) begin
      run(OP_SETFEAT, ft[i]);
      chk("feat", st, fs[i]);
      chk("io16", sixteen_bit_io_flag, !fs[i][6]);
    end
    chk("flush", host.flushN, 32'h0000_0001);
    run(OP_SETFEAT, 8'h00, 8'h00, ERR_ABRT);
    chk("feat", st, 7'h02);
    run(OP_SETFEAT, SF_XFER_MODE, 8'h0B);
    run(OP_SETFEAT, SF_XFER_MODE, 8'h22);
    run(OP_SETFEAT, SF_XFER_MODE, 8'h43, ERR_ABRT);
    chk("modes", {pioMode, mdmaMode}, 6'h1A);
    run(OP_SETFEAT, SF_ECC_VEND);
    chk("ecc", longEccBytes, 8'h08);
    run(OP_SETFEAT, SF_ECC_FOUR);
    chk("ecc", longEccBytes, ECC_FOUR_LEN);
    run(8'h70, 8'h00, 8'h00, 8'h00, 29'h1000_0100);
    run(8'h7F, 8'h00, 8'h00, ERR_IDNF, 29'h1100_0000);
    run(8'h70, 8'h00, 8'h00, 8'h00, 29'h0100_1001);
    run(8'h70, 8'h00, 8'h00, ERR_IDNF, 29'h0100_1000);
    run(OP_SETMULT, 8'h00, 8'h01);
    chk("mult", {multipleOn, blockSize}, 9'h101);
    run(OP_SETMULT, 8'h00, 8'h02, ERR_ABRT);
    chk("mult", multipleOn, 1'b0);
    run(OP_SETMULT, 8'h00, 8'h01);
    run(OP_SETMULT);
    chk("mult", multipleOn, 1'b0);
    run(OP_SETMULT, 8'h00, 8'h01);
    pulse(1'b0);
    chk("mult", multipleOn, 1'b0);
    run(OP_SETFEAT, SF_KEEP_ON);
    run(OP_SETMULT, 8'h00, 8'h01);
    pulse(1'b0);
    chk("mult", multipleOn, 1'b1);
    pulse(1'b1);
    chk("mult", multipleOn, 1'b0);
    unl(OP_UNLOCK, 16'h0000, 32'h0BAD_0BAD, ERR_ABRT);
    chk("tries", unlockTries, 3'h4);
    unl(OP_UNLOCK, 16'h0001, masterPw, ERR_ABRT);
    chk("tries", unlockTries, 3'h4);
    unl(OP_UNLOCK, 16'h0000, userPw, 8'h00);
    chk("ok", okS, 1'b1);
    highSecurity = 1'b1;
    unl(OP_UNLOCK, 16'h0001, masterPw, 8'h00);
    chk("ok", okS, 1'b1);
    repeat (4) unl(OP_UNLOCK, 16'h0000, 32'h0BAD_0BAD, ERR_ABRT);
    chk("tries", unlockTries, 3'h0);
    unl(OP_UNLOCK, 16'h0000, userPw, ERR_ABRT);
    unl(OP_ERASE_UNIT, 16'h0000, userPw, ERR_ABRT);
    pulse(1'b1);
    chk("tries", unlockTries, UNLOCK_TRIES);
    locked = 1'b0;
    unl(OP_UNLOCK, 16'h0000, 32'h0BAD_0BAD, 8'h00);
    chk("tries", unlockTries, UNLOCK_TRIES);
    run(OP_SLEEP_A);
    chk("sleep", sleeping, 1'b1);
    run(OP_SETFEAT, SF_NOP_A);
    chk("sleep", sleeping, 1'b0);
    run(OP_SLEEP_B);
    chk("sleep", sleeping, 1'b1);
    run(OP_SETFEAT, SF_NOP_A);
    ce = 1'b0;
    repeat (30) @(negedge clk);
    chk("sleep", sleeping, 1'b0);
    ce = 1'b1;
    repeat (19) @(negedge clk);
    chk("sleep", sleeping, 1'b0);
    repeat (1) @(negedge clk);
    chk("sleep", sleeping, 1'b1);
    report_and_stop();
  end
endmodule // tb_top
bind ccu_cmd_unit ccu_cmd_asserts u_chk (.*);
`default_nettype wire
